// *** oamd_decoder.sv ***
`timescale 1ns/10ps
module oamd_decoder
  import oamd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic start, // take req this cycle
  input wire oamd_req_t req,
  output logic busy,
  output logic mem_req, // byte read request, held until ack
  output logic [15:0] mem_addr,
  input wire logic mem_ack, // one-cycle, rdata valid
  input wire logic [7:0] mem_rdata,
  output logic done, // one-cycle answer strobe
  output oamd_res_t res
);

  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [1:0] {
    OAMD_IDLE, OAMD_FETCH, OAMD_PTR, OAMD_CALC
  } oamd_state_t;

  oamd_state_t state_r; // sequencer state
  oamd_req_t req_r; // latched request
  oamd_plan_t plan; // plan of the latched mode
  oamd_plan_t plan_in; // plan of the incoming mode
  logic [1:0] cnt_r; // bytes taken in the current phase
  logic [15:0] pc_r; // walks the instruction stream
  logic [15:0] addr_r; // address shown to memory
  logic [15:0] acc_r; // address, offset or immediate bytes
  logic [15:0] val_r; // pointer read from memory
  logic [7:0] rel_r; // branch offset
  logic refuse_r; // request was refused
  logic done_r;
  oamd_res_t res_r;
  logic take; // accepted memory byte
  logic last_ins; // final stream byte arrives
  logic last_ptr; // final pointer byte arrives
  logic refuse_in; // incoming request must be refused

  assign plan = oamd_plan(req_r.mode);
  assign plan_in = oamd_plan(req.mode);
  assign take = mem_ack && mem_req;
  assign last_ins = take && state_r == OAMD_FETCH &&
                    cnt_r == plan.ins - 2'h1;
  assign last_ptr = take && state_r == OAMD_PTR &&
                    cnt_r == plan.ptr - 2'h1;
  // read-modify-write work only fits the short forms
  assign refuse_in = req.rmw && plan_in.longm;

  // busy and mem_req straight from state, done and data from flops
  assign busy = state_r != OAMD_IDLE;
  assign mem_req = state_r == OAMD_FETCH || state_r == OAMD_PTR;
  assign mem_addr = addr_r;
  assign done = done_r;
  assign res = res_r;

  // ==========================================================
  // sequencer
  // ==========================================================
  // stream bytes first, then pointer bytes, then one calc cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= OAMD_IDLE;
    end else begin
      case (state_r)
        OAMD_IDLE: begin
          if (start) begin
            // inherent and refused requests skip all fetches
            if (refuse_in || plan_in.ins == 2'h0) begin
              state_r <= OAMD_CALC;
            end else begin
              state_r <= OAMD_FETCH;
            end
          end
        end
        OAMD_FETCH: begin
          if (last_ins) begin
            // pointer read only after its address is known
            state_r <= (plan.ptr != 2'h0) ? OAMD_PTR : OAMD_CALC;
          end
        end
        OAMD_PTR: begin
          if (last_ptr) begin
            state_r <= OAMD_CALC;
          end
        end
        OAMD_CALC: state_r <= OAMD_IDLE;
        default: state_r <= OAMD_IDLE;
      endcase
    end
  end

  // request latch; start is ignored while busy
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_r <= '0;
      refuse_r <= 1'b0;
    end else if (state_r == OAMD_IDLE && start) begin
      req_r <= req;
      refuse_r <= refuse_in;
    end
  end

  // byte counter, restarts per phase
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= OAMD_CNT_RST;
    end else if (state_r == OAMD_IDLE || last_ins || last_ptr) begin
      cnt_r <= OAMD_CNT_RST;
    end else if (take) begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  // ==========================================================
  // memory address
  // ==========================================================
  // the stream counter ends just past the last fetched stream byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pc_r <= OAMD_ADDR_RST;
    end else if (state_r == OAMD_IDLE && start) begin
      pc_r <= req.pc;
    end else if (take && state_r == OAMD_FETCH) begin
      pc_r <= pc_r + 16'h0001;
    end
  end

  // pointer address is always the first stream byte, page zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_r <= OAMD_ADDR_RST;
    end else if (state_r == OAMD_IDLE && start) begin
      addr_r <= req.pc;
    end else if (last_ins) begin
      if (cnt_r == 2'h0) begin
        addr_r <= {OAMD_BYTE_RST, mem_rdata};
      end else begin
        addr_r <= {OAMD_BYTE_RST, acc_r[7:0]};
      end
    end else if (take) begin
      // word pointers wrap across the whole space
      addr_r <= addr_r + 16'h0001;
    end
  end

  // ==========================================================
  // operand bytes
  // ==========================================================
  // cleared at start so that one byte lands in page zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc_r <= OAMD_ADDR_RST;
    end else if (state_r == OAMD_IDLE && start) begin
      acc_r <= OAMD_ADDR_RST;
    end else if (take && state_r == OAMD_FETCH &&
                 !(last_ins && plan.rel_tail)) begin
      acc_r <= {acc_r[7:0], mem_rdata};
    end
  end

  // pointer word, first byte high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      val_r <= OAMD_ADDR_RST;
    end else if (state_r == OAMD_IDLE && start) begin
      val_r <= OAMD_ADDR_RST;
    end else if (take && state_r == OAMD_PTR && !plan.ptr_rel) begin
      val_r <= {val_r[7:0], mem_rdata};
    end
  end

  // branch offset from the stream tail or from memory
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rel_r <= OAMD_BYTE_RST;
    end else if (state_r == OAMD_IDLE && start) begin
      rel_r <= OAMD_BYTE_RST;
    end else if (last_ins && plan.rel_tail) begin
      rel_r <= mem_rdata;
    end else if (take && state_r == OAMD_PTR && plan.ptr_rel) begin
      rel_r <= mem_rdata;
    end
  end

  // ==========================================================
  // answer
  // ==========================================================
  // index added unsigned, no wrap into sign
  function automatic logic [15:0] add_index(input logic [15:0] b,
                                            input logic [7:0] i);
    return b + {OAMD_BYTE_RST, i};
  endfunction : add_index

  logic [15:0] base; // address word before indexing
  logic [7:0] index; // selected index register
  logic [15:0] target; // branch destination
  assign base = (plan.ptr == 2'h2 || (plan.ptr == 2'h1 &&
                 !plan.ptr_rel)) ? val_r : acc_r;
  assign index = req_r.use_y ? req_r.y : req_r.x;
  // pc_r already points past the branch
  assign target = pc_r + {{8{rel_r[7]}}, rel_r};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_r <= 1'b0;
    end else begin
      done_r <= state_r == OAMD_CALC;
    end
  end

  // result built in the calc cycle, held until the next
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res_r <= '0;
    end else if (state_r == OAMD_CALC) begin
      res_r.illegal <= refuse_r;
      res_r.target <= target;
      // bit-relative keeps its page-zero operand address in ea
      if (plan.ptr_rel || (plan.rel_tail && plan.ins == 2'h1)) begin
        res_r.ea <= target;
      end else if (plan.idx) begin
        res_r.ea <= add_index(base, index);
      end else begin
        res_r.ea <= base;
      end
      res_r.operand <= acc_r[7:0];
      res_r.has_operand <= req_r.mode == OAMD_IMM;
      if (req_r.mode == OAMD_IDX_0 && req_r.use_y) begin
        res_r.len <= OAMD_LEN_OPC + plan.len + OAMD_LEN_Y;
      end else begin
        res_r.len <= OAMD_LEN_OPC + plan.len;
      end
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic calc_q; // mirrors calc one cycle late
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      calc_q <= 1'b0;
    end else begin
      calc_q <= state_r == OAMD_CALC;
    end
  end

  rmw_refuse_a: assert property (
    !busy && start && req.rmw && plan_in.longm
    |-> ##1 !mem_req ##1 done && res.illegal)
    else $error("long rmw not refused");

  inherent_len_a: assert property (
    !busy && start && req.mode == OAMD_INH && !req.rmw
    |-> (!mem_req)[*2] ##1 done && res.len == 3'h1)
    else $error("inherent not one byte");

  immediate_a: assert property (
    done && req_r.mode == OAMD_IMM |->
    res.has_operand && res.len == 3'h2 && res.operand == acc_r[7:0])
    else $error("immediate value wrong");

  short_page_a: assert property (
    done && (req_r.mode == OAMD_DIR_S || req_r.mode == OAMD_IND_S)
    |-> res.ea[15:8] == 8'h00)
    else $error("short address off page zero");

  long_dir_a: assert property (
    done && req_r.mode == OAMD_DIR_L && !res.illegal
    |-> res.len == 3'h3 && res.ea == acc_r)
    else $error("long direct wrong");

  index_sum_a: assert property (
    done && plan.idx && !res.illegal && plan.ptr == 2'h0
    |-> res.ea == acc_r + {8'h00, index})
    else $error("indexed sum wrong");

  no_offset_a: assert property (
    done && req_r.mode == OAMD_IDX_0
    |-> res.ea == {8'h00, index} &&
        res.len == (req_r.use_y ? 3'h2 : 3'h1))
    else $error("no-offset index wrong");

  ptr_page_a: assert property (
    state_r == OAMD_PTR && cnt_r == 2'h0
    |-> mem_req && mem_addr[15:8] == 8'h00)
    else $error("pointer not in page zero");

  word_msb_a: assert property (
    take && state_r == OAMD_FETCH && cnt_r == 2'h0 &&
    plan.ins == 2'h2 && !plan.rel_tail
    |=> acc_r[7:0] == $past(mem_rdata))
    else $error("word byte order wrong");

  rel_target_a: assert property (
    done && (plan.rel_tail || plan.ptr_rel)
    |-> res.target == pc_r + {{8{rel_r[7]}}, rel_r} && calc_q)
    else $error("branch target wrong");

  rel_ea_a: assert property (
    done && (req_r.mode == OAMD_REL_D || req_r.mode == OAMD_REL_I)
    |-> res.ea == res.target)
    else $error("relative address not the target");

  mem_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped before answer");

  ptr_order_a: assert property (
    state_r == OAMD_PTR |-> plan.ptr != 2'h0 &&
    $past(state_r) != OAMD_IDLE)
    else $error("pointer read before its address");

  short_index_a: assert property (
    done && (req_r.mode == OAMD_IDX_S || req_r.mode == OAMD_IIX_S)
    |-> res.ea <= 16'h01FE)
    else $error("short indexed reach exceeded");

  bit_page_a: assert property (
    done && req_r.mode inside {OAMD_BIT_D, OAMD_BIT_I, OAMD_BIT_DR,
                               OAMD_BIT_IR}
    |-> res.ea[15:8] == 8'h00)
    else $error("bit operand off page zero");

  long_ind_a: assert property (
    done && req_r.mode == OAMD_IND_L && !res.illegal
    |-> res.ea == val_r && res.len == 3'h3)
    else $error("long indirect wrong");

  done_idle_a: assert property (
    done |-> !busy && !mem_req)
    else $error("answer while still working");

  long_ind_c: cover property (done && req_r.mode == OAMD_IIX_L);
  idx_y_c: cover property (done && req_r.mode == OAMD_IDX_0 && req_r.use_y);
  bit_rel_c: cover property (done && req_r.mode == OAMD_BIT_IR);
  refuse_c: cover property (done && res.illegal);
  rel_back_c: cover property (done && plan.rel_tail && rel_r[7]);

endmodule : oamd_decoder

// *** oamd_pkg.sv ***
package oamd_pkg;

  // ==========================================================
  // constants
  // ==========================================================
  localparam logic [15:0] OAMD_ADDR_RST = 16'h0000; // address reset
  localparam logic [7:0] OAMD_BYTE_RST = 8'h00; // byte reset
  localparam logic [2:0] OAMD_LEN_OPC = 3'h1; // opcode byte itself
  localparam logic [2:0] OAMD_LEN_Y = 3'h1; // y selector byte
  localparam logic [1:0] OAMD_CNT_RST = 2'h0; // byte counter reset

  // ==========================================================
  // types
  // ==========================================================
  // seventeen modes, listed group by group
  typedef enum logic [4:0] {
    OAMD_INH, OAMD_IMM, OAMD_DIR_S, OAMD_DIR_L,
    OAMD_IDX_0, OAMD_IDX_S, OAMD_IDX_L,
    OAMD_IND_S, OAMD_IND_L, OAMD_IIX_S, OAMD_IIX_L,
    OAMD_REL_D, OAMD_REL_I,
    OAMD_BIT_D, OAMD_BIT_I, OAMD_BIT_DR, OAMD_BIT_IR
  } oamd_mode_t;

  // per-mode fetch plan
  typedef struct packed {
    logic [1:0] ins; // bytes fetched after the opcode
    logic [1:0] ptr; // pointer bytes read from memory
    logic [2:0] len; // operand bytes of the instruction
    logic idx; // index register added
    logic rel_tail; // last stream byte is a branch offset
    logic ptr_rel; // pointer byte is a branch offset
    logic longm; // long sub-mode
  } oamd_plan_t;

  // request taken with start
  typedef struct packed {
    oamd_mode_t mode;
    logic use_y; // second index register selected
    logic rmw; // read-modify-write instruction
    logic [15:0] pc; // address of first byte after opcode
    logic [7:0] x;
    logic [7:0] y;
  } oamd_req_t;

  // answer given with done
  typedef struct packed {
    logic [15:0] ea; // operand address or branch target
    logic [15:0] target; // branch target
    logic [7:0] operand; // immediate value
    logic [2:0] len; // whole instruction length
    logic has_operand; // operand field is valid
    logic illegal; // refused combination
  } oamd_res_t;

  // mode to fetch plan
  function automatic oamd_plan_t oamd_plan(input oamd_mode_t m);
    oamd_plan_t p;
    p = '0;
    case (m)
      OAMD_INH: p.len = 3'h0;
      OAMD_IMM: begin p.ins = 2'h1; p.len = 3'h1; end
      OAMD_DIR_S: begin p.ins = 2'h1; p.len = 3'h1; end
      OAMD_DIR_L: begin
        p.ins = 2'h2; p.len = 3'h2; p.longm = 1'b1;
      end
      OAMD_IDX_0: p.idx = 1'b1;
      OAMD_IDX_S: begin
        p.ins = 2'h1; p.len = 3'h1; p.idx = 1'b1;
      end
      OAMD_IDX_L: begin
        p.ins = 2'h2; p.len = 3'h2; p.idx = 1'b1; p.longm = 1'b1;
      end
      OAMD_IND_S: begin
        p.ins = 2'h1; p.ptr = 2'h1; p.len = 3'h2;
      end
      OAMD_IND_L: begin
        p.ins = 2'h1; p.ptr = 2'h2; p.len = 3'h2; p.longm = 1'b1;
      end
      OAMD_IIX_S: begin
        p.ins = 2'h1; p.ptr = 2'h1; p.len = 3'h2; p.idx = 1'b1;
      end
      OAMD_IIX_L: begin
        p.ins = 2'h1; p.ptr = 2'h2; p.len = 3'h2; p.idx = 1'b1;
        p.longm = 1'b1;
      end
      OAMD_REL_D: begin
        p.ins = 2'h1; p.len = 3'h1; p.rel_tail = 1'b1;
      end
      OAMD_REL_I: begin
        p.ins = 2'h1; p.ptr = 2'h1; p.len = 3'h2; p.ptr_rel = 1'b1;
      end
      OAMD_BIT_D: begin p.ins = 2'h1; p.len = 3'h1; end
      OAMD_BIT_I: begin p.ins = 2'h1; p.ptr = 2'h1; p.len = 3'h2; end
      OAMD_BIT_DR: begin
        p.ins = 2'h2; p.len = 3'h2; p.rel_tail = 1'b1;
      end
      OAMD_BIT_IR: begin
        p.ins = 2'h2; p.ptr = 2'h1; p.len = 3'h3; p.rel_tail = 1'b1;
      end
      default: p = '0;
    endcase
    return p;
  endfunction : oamd_plan

endpackage : oamd_pkg

// *** oamd_mem_model.sv ***
`timescale 1ns/10ps
module oamd_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow, // two wait cycles before each answer
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  // ==========================================================
  // contents
  // ==========================================================
  // both address bytes feed the data, so a wrong page shows up
  function automatic logic [7:0] mem_byte(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'ha5;
  endfunction : mem_byte

  int wcnt; // cycles already waited on this request

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    wcnt = 0;
  end

  // ==========================================================
  // answer loop
  // ==========================================================
  // acts just after each edge, once the request has settled
  always @(posedge clk) begin
    #1;
    if (!resetn || !mem_req) begin
      wcnt = 0;
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata; // idle bus never keeps old data
    end else if (wcnt >= (slow ? 2 : 0)) begin
      wcnt = 0;
      mem_ack = 1'b1;
      mem_rdata = mem_byte(mem_addr);
    end else begin
      wcnt++;
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule : oamd_mem_model

// *** oamd_decoder_tb.sv ***
`timescale 1ns/10ps
module oamd_decoder_tb
  import oamd_pkg::*;
;
  // ==========================================================
  // signals
  // ==========================================================
  typedef struct packed {
    oamd_res_t r;
    logic [3:0] chk; // ea, target, operand, len/flags
  } oamd_note_t;
  logic clk, resetn, start, busy, mem_req, mem_ack, done, slow;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  oamd_req_t req;
  oamd_res_t res;
  oamd_note_t notes[$]; // expected answers, oldest first
  oamd_note_t got_note;
  int mismatches, n_tests, seed;
  // operand bytes of each mode, in mode order
  localparam logic [2:0] EXTRA_LEN [0:16] = '{3'h0, 3'h1, 3'h1, 3'h2,
    3'h0, 3'h1, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h2, 3'h1, 3'h2,
    3'h2, 3'h3};

  oamd_decoder i_oamd_decoder (.clk(clk), .resetn(resetn), .start(start),
    .req(req), .busy(busy), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .done(done), .res(res));

  oamd_mem_model i_oamd_mem_model (.clk(clk), .resetn(resetn),
    .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ==========================================================
  // helpers
  // ==========================================================
  // own copy of the memory contents, kept apart from the model
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'ha5;
  endfunction : mb

  task automatic chk_word(input string what, input logic [15:0] exp,
                          input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bits(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk_bits

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // driver: note the answer, then send one request
  // ==========================================================
  // poke holds start high one more cycle, with mode OAMD_INH, while busy; it must be ignored
  task automatic issue(input oamd_mode_t m, input logic uy,
                       input logic rw, input logic poke);
    oamd_note_t e;
    logic [31:0] r;
    logic [15:0] pc, p, w;
    logic [7:0] b0, b1, xy;
    int n;
    r = $random(seed);
    pc = r[15:0];
    xy = uy ? r[31:24] : r[23:16];
    b0 = mb(pc);
    b1 = mb(pc + 16'h0001);
    p = {8'h00, b0}; // pointers live in page zero
    w = {mb(p), mb(p + 16'h0001)}; // high byte first
    e = '0;
    e.r.len = EXTRA_LEN[m] + 3'h1 + ((m == OAMD_IDX_0 && uy) ? 3'h1 : 3'h0);
    e.chk[0] = !(m inside {OAMD_INH, OAMD_IMM});
    e.chk[1] = m inside {OAMD_REL_D, OAMD_REL_I, OAMD_BIT_DR, OAMD_BIT_IR};
    e.chk[2] = (m == OAMD_IMM);
    e.chk[3] = 1'b1;
    case (m)
      OAMD_IMM: begin
        e.r.operand = b0;
        e.r.has_operand = 1'b1;
      end
      OAMD_DIR_L: e.r.ea = {b0, b1};
      OAMD_IDX_0: e.r.ea = {8'h00, xy};
      OAMD_IDX_S: e.r.ea = {8'h00, b0} + {8'h00, xy};
      OAMD_IDX_L: e.r.ea = {b0, b1} + {8'h00, xy};
      OAMD_IND_S, OAMD_BIT_I: e.r.ea = {8'h00, w[15:8]};
      OAMD_IND_L: e.r.ea = w;
      OAMD_IIX_S: e.r.ea = {8'h00, w[15:8]} + {8'h00, xy};
      OAMD_IIX_L: e.r.ea = w + {8'h00, xy};
      OAMD_REL_D: e.r.ea = pc + 16'h0001 + {{8{b0[7]}}, b0};
      OAMD_REL_I: e.r.ea = pc + 16'h0001 + {{8{w[15]}}, w[15:8]};
      OAMD_BIT_IR: e.r.ea = {8'h00, w[15:8]};
      default: e.r.ea = {8'h00, b0};
    endcase
    e.r.target = m inside {OAMD_REL_D, OAMD_REL_I} ? e.r.ea :
                 pc + 16'h0002 + {{8{b1[7]}}, b1};
    if (rw && m inside {OAMD_DIR_L, OAMD_IDX_L, OAMD_IND_L, OAMD_IIX_L})
    begin
      e.r.illegal = 1'b1;
      e.chk = 4'h0;
    end
    notes.push_back(e);
    start = 1'b1;
    req = '{mode: m, use_y: uy, rmw: rw, pc: pc, x: r[23:16], y: r[31:24]};
    @(posedge clk);
    #1;
    if (poke) begin
      req.mode = OAMD_INH;
      @(posedge clk);
      #1;
    end
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      chk_bits("done within bound", 8'h01, 8'h00);
    end
  endtask : issue

  // ==========================================================
  // monitor: each done takes the oldest note
  // ==========================================================
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        chk_bits("done without request", 8'h00, 8'h01);
      end else begin
        got_note = notes.pop_front();
        chk_bits("illegal", {7'h0, got_note.r.illegal},
                 {7'h0, res.illegal});
        if (got_note.chk[3]) begin
          chk_bits("len", {5'h0, got_note.r.len}, {5'h0, res.len});
          chk_bits("has_operand", {7'h0, got_note.r.has_operand},
                   {7'h0, res.has_operand});
        end
        if (got_note.chk[0]) begin
          chk_word("ea", got_note.r.ea, res.ea);
        end
        if (got_note.chk[1]) begin
          chk_word("target", got_note.r.target, res.target);
        end
        if (got_note.chk[2]) begin
          chk_bits("operand", got_note.r.operand, res.operand);
        end
      end
    end
  end

  // ==========================================================
  // clock, watchdog, main sequence
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // whole run needs about 700 cycles; this is over forty times that
  initial begin
    #300000;
    mismatches++;
    report_and_stop();
  end

  // every mode, both index registers, with and without rmw, fast and slow
  initial begin
    resetn = 1'b0;
    start = 1'b0;
    req = '0;
    slow = 1'b0;
    seed = 57;
    mismatches = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    #1;
    chk_bits("idle outputs", 8'h00, {5'h0, busy, mem_req, done});
    chk_word("res in reset", 16'h0000, res.ea);
    resetn = 1'b1;
    for (int pass = 0; pass < 2; pass++) begin
      slow = pass[0];
      for (int i = 0; i < 17; i++) begin
        for (int k = 0; k < 4; k++) begin
          issue(oamd_mode_t'(i), k[0], k[1], 1'b0);
        end
      end
      issue(OAMD_IND_L, 1'b0, 1'b0, 1'b1);
      $display("test pass %0d finished", pass);
    end
    repeat (4) @(posedge clk);
    chk_word("unanswered", 16'h0000, 16'(notes.size()));
    report_and_stop();
  end
endmodule : oamd_decoder_tb
